/* File: core/can_flag_pkg.sv */
// constants for the upper can interrupt flag block and its register map
// Operation
// R1: overload frame sent while error active or passive sets flag bit 15; write 1 clears
// R2: transmit error count reaching 256 sets bus-off flag bit 14; write 1 clears
// R3: either error count reaching 128 sets error-passive flag bit 13; write 1 clears
// R4: receive error count reaching 96 sets receive warning flag bit 12; write 1 clears
// R5: transmit error count reaching 96 sets transmit warning flag bit 11; write 1 clears
// R6: remote frame done in unmasked mailbox sets read-only remote summary flag bit 10
// R7: remote summary clears only once all remote request status bits are clear
// R8: data or remote frame done in unmasked mailbox sets receive summary bit 9
// R9: receive summary clears only once all receive complete status bits are clear
// R10: a remote request status bit sets its receive complete bit in the same cycle
// R11: error-free reception sets mailbox receive complete bit 0 to 15; write 1 clears
// R12: writing 0 leaves flags alone; a set in the clearing cycle wins
package can_flag_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [7:0]  OFS_FLAGS    = 8'h00;
    localparam logic [7:0]  OFS_RXDONE   = 8'h04;
    localparam logic [7:0]  OFS_REMOTE   = 8'h08;
    localparam logic [7:0]  OFS_MBXMASK  = 8'h0C;
    localparam logic [7:0]  OFS_IRQSTAT  = 8'h10;
    localparam logic [7:0]  OFS_IRQMASK  = 8'h14;
    // field positions inside the flag register
    localparam int          FLAG_LSB     = 9;
    localparam int          ERR_LSB      = 11;
    localparam int          NUM_ERR      = 5;
    localparam int          NUM_EVT      = 7;
    localparam int          NUM_MBX      = 16;
    // error counter thresholds
    localparam logic [8:0]  TH_BUS_OFF   = 9'h100;
    localparam logic [8:0]  TH_PASSIVE   = 9'h080;
    localparam logic [8:0]  TH_WARNING   = 9'h060;
    // reset values
    localparam logic [15:0] RST_MBXMASK  = 16'hFFFF;
    localparam logic [6:0]  RST_IRQMASK  = 7'h00;
    localparam logic [31:0] RST_DATA     = 32'h0000_0000;
endpackage

/* File: core/mailbox_status.sv */
// per-mailbox receive complete and remote request status bits
`timescale 1ns/1ps
`default_nettype none
module mailbox_status (
    input  wire logic        clk_i,        // module clock
    input  wire logic        rst_i,        // synchronous reset, high
    input  wire logic        ce_i,         // clock enable
    input  wire logic        rx_done_i,    // error-free reception pulse
    input  wire logic        rx_remote_i,  // the received frame was remote
    input  wire logic [3:0]  rx_mbx_i,     // mailbox that received
    input  wire logic [15:0] rxdone_clr_i, // write-1 clear, receive complete
    input  wire logic [15:0] remote_clr_i, // write-1 clear, remote request
    output logic      [15:0] rxdone_o,     // receive complete status
    output logic      [15:0] remote_o      // remote request status
);
    // one set/clear cell per mailbox; a set in the clearing cycle wins
    genvar g;
    generate
        for (g = 0; g < can_flag_pkg::NUM_MBX; g++) begin : g_mbx
            logic hit;
            assign hit = rx_done_i && (rx_mbx_i == 4'(g));
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    rxdone_o[g] <= 1'b0;
                    remote_o[g] <= 1'b0;
                end else if (ce_i) begin
                    rxdone_o[g] <= hit | (rxdone_o[g] & ~rxdone_clr_i[g]);  // R11 R12
                    remote_o[g] <= (hit & rx_remote_i) | (remote_o[g] & ~remote_clr_i[g]);  // R10
                end
            end
        end
    endgenerate

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_remote_pairs_rx: assert property (ce_i && rx_done_i && rx_remote_i |=> // R10
        remote_o[$past(rx_mbx_i)] && rxdone_o[$past(rx_mbx_i)])
        else $error("remote request set without receive complete");
    a_rx_done_set: assert property (ce_i && rx_done_i |=> rxdone_o[$past(rx_mbx_i)]) // R11
        else $error("receive complete bit not set");
    a_clear_all_rx: assert property (ce_i && !rx_done_i && rxdone_clr_i == 16'hFFFF |=> rxdone_o == 16'h0000) // R11
        else $error("receive complete bits not cleared by write of ones");
endmodule // mailbox_status
`default_nettype wire

/* File: core/can_flag_upper.sv */
// upper can interrupt flags with mailbox status, wishbone slave and interrupt
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module can_flag_upper (
    input  wire logic        clk_i,        // module clock, 25 MHz
    input  wire logic        rst_i,        // synchronous reset, high
    input  wire logic        ce_i,         // clock enable, freezes all state when low
    input  wire logic        wb_cyc_i,     // wishbone cycle
    input  wire logic        wb_stb_i,     // wishbone strobe
    input  wire logic        wb_we_i,      // wishbone write enable
    input  wire logic [7:0]  wb_adr_i,     // wishbone byte address
    input  wire logic [3:0]  wb_sel_i,     // wishbone byte selects
    input  wire logic [31:0] wb_dat_i,     // wishbone write data
    output logic      [31:0] wb_dat_o,     // wishbone read data
    output logic             wb_ack_o,     // wishbone acknowledge
    output logic             irq_o,        // level interrupt
    input  wire logic        ovl_sent_i,   // overload frame transmitted, pulse
    input  wire logic [8:0]  tec_i,        // transmit error counter
    input  wire logic [8:0]  rec_i,        // receive error counter
    input  wire logic        rx_done_i,    // error-free reception, pulse
    input  wire logic        rx_remote_i,  // received frame is remote
    input  wire logic [3:0]  rx_mbx_i      // mailbox of the reception
);
    // flag bits 15..11 as one vector, index 4 = overload, 0 = tx warning
    logic [4:0]  err_flags_r;
    logic        remote_sum_r;
    logic        rxmsg_sum_r;
    logic [4:0]  err_cond;
    logic [4:0]  err_cond_r;
    logic [4:0]  err_evt;
    logic        remote_sum_evt;
    logic        rxmsg_sum_evt;
    logic [15:0] mbx_mask_r;
    logic [6:0]  irq_stat_r;
    logic [6:0]  irq_mask_r;
    logic [6:0]  irq_evt;
    logic [6:0]  stat_unread;
    logic [15:0] rxdone;
    logic [15:0] remote;
    logic [15:0] rxdone_clr;
    logic [15:0] remote_clr;
    logic [15:0] flag_word;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic [31:0] rd_nxt;
    logic [7:0]  adr_word;
    logic        req;
    logic        wr_take;
    logic        rd_take;
    logic        unmasked_hit;

    // bus decode: the access takes effect on the edge where ack is high
    assign req      = wb_cyc_i && wb_stb_i;
    assign wr_take  = ce_i && req && wb_ack_o && wb_we_i;
    assign rd_take  = ce_i && req && wb_ack_o && !wb_we_i;
    assign adr_word = {wb_adr_i[7:2], 2'b00};
    assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wbits    = wb_dat_i & wmask;

    // current flag register image; bit 8 and below are not part of this block
    assign flag_word = {err_flags_r, remote_sum_r, rxmsg_sum_r, 9'h000};

    // threshold conditions from the protocol engine, same clock, no sync needed
    // overload only counts while not bus-off, i.e. active or passive
    assign err_cond[4] = ovl_sent_i && (tec_i < can_flag_pkg::TH_BUS_OFF);    // R1
    assign err_cond[3] = tec_i >= can_flag_pkg::TH_BUS_OFF;                   // R2
    assign err_cond[2] = (tec_i >= can_flag_pkg::TH_PASSIVE) ||
                         (rec_i >= can_flag_pkg::TH_PASSIVE);                 // R3
    assign err_cond[1] = rec_i >= can_flag_pkg::TH_WARNING;                   // R4
    assign err_cond[0] = tec_i >= can_flag_pkg::TH_WARNING;                   // R5

    // counter states fire on entry so software can clear while the state persists
    assign err_evt[4]   = err_cond[4];                                        // R1
    assign err_evt[3:0] = err_cond[3:0] & ~err_cond_r[3:0];

    // mailbox events only reach the summaries if that mailbox is unmasked
    assign unmasked_hit   = rx_done_i && !mbx_mask_r[rx_mbx_i];
    assign remote_sum_evt = unmasked_hit && rx_remote_i;                      // R6
    assign rxmsg_sum_evt  = unmasked_hit;                                     // R8
    assign irq_evt        = {err_evt, remote_sum_evt, rxmsg_sum_evt};

    // write-1 clears toward the mailbox status cells
    assign rxdone_clr = (wr_take && adr_word == can_flag_pkg::OFS_RXDONE) ? wbits[15:0] : 16'h0000;  // R11
    assign remote_clr = (wr_take && adr_word == can_flag_pkg::OFS_REMOTE) ? wbits[15:0] : 16'h0000;

    mailbox_status u_mbx (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .ce_i         (ce_i),
        .rx_done_i    (rx_done_i),
        .rx_remote_i  (rx_remote_i),
        .rx_mbx_i     (rx_mbx_i),
        .rxdone_clr_i (rxdone_clr),
        .remote_clr_i (remote_clr),
        .rxdone_o     (rxdone),
        .remote_o     (remote)
    );

    // previous counter conditions for entry detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_cond_r <= 5'h00;
        end else if (ce_i) begin
            err_cond_r <= err_cond;
        end
    end

    // error flags: set wins over a write of 1, a write of 0 keeps the bit
    genvar g;
    generate
        for (g = 0; g < can_flag_pkg::NUM_ERR; g++) begin : g_err
            logic clr;
            assign clr = wr_take && (adr_word == can_flag_pkg::OFS_FLAGS) &&
                         wbits[can_flag_pkg::ERR_LSB + g];
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    err_flags_r[g] <= 1'b0;
                end else if (ce_i) begin
                    err_flags_r[g] <= err_evt[g] | (err_flags_r[g] & ~clr);  // R1 R2 R3 R4 R5 R12
                end
            end
        end
    endgenerate

    // summary flags ignore writes and follow their status registers
    // the set event wins, so a frame landing as software empties the register is kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            remote_sum_r <= 1'b0;
        end else if (ce_i) begin
            if (remote_sum_evt) begin
                remote_sum_r <= 1'b1;                                         // R6
            end else if (remote == 16'h0000) begin
                remote_sum_r <= 1'b0;                                         // R7
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxmsg_sum_r <= 1'b0;
        end else if (ce_i) begin
            if (rxmsg_sum_evt) begin
                rxmsg_sum_r <= 1'b1;                                          // R8
            end else if (rxdone == 16'h0000) begin
                rxmsg_sum_r <= 1'b0;                                          // R9
            end
        end
    end

    // software-owned mailbox interrupt mask, 1 masks the mailbox
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mbx_mask_r <= can_flag_pkg::RST_MBXMASK;
        end else if (ce_i && wr_take && adr_word == can_flag_pkg::OFS_MBXMASK) begin
            mbx_mask_r <= (mbx_mask_r & ~wmask[15:0]) | wbits[15:0];
        end
    end

    // interrupt enable mask, same layout as the flag bits 15..9
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_r <= can_flag_pkg::RST_IRQMASK;
        end else if (ce_i && wr_take && adr_word == can_flag_pkg::OFS_IRQMASK) begin
            irq_mask_r <= (irq_mask_r & ~wmask[15:9]) | wbits[15:9];
        end
    end

    // sticky event status; a read clears only the bits it returned, because the data is
    // captured a cycle before the clear and an event in between must wait for the next read
    assign stat_unread = irq_stat_r & ~wb_dat_o[15:9];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= 7'h00;
        end else if (ce_i) begin
            if (rd_take && adr_word == can_flag_pkg::OFS_IRQSTAT) begin
                irq_stat_r <= stat_unread | irq_evt;
            end else begin
                irq_stat_r <= irq_stat_r | irq_evt;
            end
        end
    end

    // interrupt line registered, so it trails the status bit by one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end

    // read mux; unmapped addresses read zero and are still acknowledged
    always_comb begin
        rd_nxt = can_flag_pkg::RST_DATA;
        case (adr_word)
            can_flag_pkg::OFS_FLAGS:   rd_nxt[15:0] = flag_word;
            can_flag_pkg::OFS_RXDONE:  rd_nxt[15:0] = rxdone;
            can_flag_pkg::OFS_REMOTE:  rd_nxt[15:0] = remote;
            can_flag_pkg::OFS_MBXMASK: rd_nxt[15:0] = mbx_mask_r;
            can_flag_pkg::OFS_IRQSTAT: rd_nxt[15:9] = irq_stat_r;
            can_flag_pkg::OFS_IRQMASK: rd_nxt[15:9] = irq_mask_r;
            default:                   rd_nxt = can_flag_pkg::RST_DATA;
        endcase
    end

    // ack one cycle after the request, dropped the cycle after;
    // read data is captured with the ack so it stands stable while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= can_flag_pkg::RST_DATA;
        end else if (ce_i) begin
            wb_ack_o <= req && !wb_ack_o;
            if (req && !wb_ack_o && !wb_we_i) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

    // checks on the flag, interrupt status and bus acknowledge behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a clearing write to the flag register
    sequence s_flag_clear_write(int b);
        wr_take && adr_word == can_flag_pkg::OFS_FLAGS && wbits[b];
    endsequence

    a_overload_set: assert property (ce_i && ovl_sent_i && tec_i < 9'h100 |=> err_flags_r[4]) // R1
        else $error("overload flag not set after overload frame");
    a_overload_busoff: assert property (ce_i && !err_flags_r[4] && !(ovl_sent_i && tec_i < 9'h100)
        |=> !err_flags_r[4]) // R1
        else $error("overload flag set without cause");
    a_bus_off_set: assert property (ce_i && tec_i >= 9'h100 && !err_cond_r[3] |=> err_flags_r[3]) // R2
        else $error("bus-off flag not set at 256");
    a_passive_set: assert property (ce_i && (tec_i >= 9'h080 || rec_i >= 9'h080) && !err_cond_r[2]
        |=> err_flags_r[2]) // R3
        else $error("error passive flag not set at 128");
    a_rx_warn_set: assert property (ce_i && rec_i >= 9'h060 && !err_cond_r[1] |=> err_flags_r[1]) // R4
        else $error("receive warning flag not set at 96");
    a_tx_warn_set: assert property (ce_i && tec_i >= 9'h060 && !err_cond_r[0] |=> err_flags_r[0]) // R5
        else $error("transmit warning flag not set at 96");
    a_tx_warn_quiet: assert property (ce_i && tec_i < 9'h060 && !err_flags_r[0] |=> !err_flags_r[0]) // R5
        else $error("transmit warning flag set below 96");
    a_remote_sum_set: assert property (ce_i && rx_done_i && rx_remote_i && !mbx_mask_r[rx_mbx_i]
        |=> remote_sum_r) // R6
        else $error("remote summary not set by unmasked remote frame");
    a_remote_sum_hold: assert property (ce_i && remote_sum_r && remote != 16'h0000 |=> remote_sum_r) // R7
        else $error("remote summary cleared while requests pending");
    a_remote_sum_clr: assert property (ce_i && remote == 16'h0000 && !rx_done_i |=> !remote_sum_r) // R7
        else $error("remote summary kept after status emptied");
    a_rxmsg_sum_set: assert property (ce_i && rx_done_i && !mbx_mask_r[rx_mbx_i] |=> rxmsg_sum_r) // R8
        else $error("receive summary not set by unmasked reception");
    a_rxmsg_sum_clr: assert property (ce_i && rxdone == 16'h0000 && !rx_done_i
        ##1 ce_i && !rx_done_i |=> !rxmsg_sum_r) // R9
        else $error("receive summary kept after status emptied");
    a_set_beats_clr: assert property (ce_i && err_evt[3] and s_flag_clear_write(14) |=> err_flags_r[3]) // R12
        else $error("clearing write beat a bus-off set");
    a_write_zero: assert property (ce_i && err_flags_r[2] && wr_take && adr_word == can_flag_pkg::OFS_FLAGS
        && !wbits[13] |=> err_flags_r[2]) // R12
        else $error("write of zero changed a flag");
    a_w1c_works: assert property (ce_i && err_flags_r[0] && !err_evt[0] and s_flag_clear_write(11)
        |=> !err_flags_r[0]) // R5
        else $error("write of one did not clear transmit warning");
    a_ack_pulse: assert property (ce_i && wb_ack_o |=> !wb_ack_o || !ce_i)
        else $error("ack held longer than one cycle");
    a_stat_unread_kept: assert property (ce_i && rd_take && adr_word == can_flag_pkg::OFS_IRQSTAT
        |=> (irq_stat_r & $past(stat_unread)) == $past(stat_unread))
        else $error("status read cleared an event it did not return");
endmodule // can_flag_upper
`default_nettype wire

/* File: verification/can_engine_model.sv */
// behavioural protocol engine feeding error counts, overload and reception events
`timescale 1ns/1ps
`default_nettype none
module can_engine_model (
    input  wire logic       clk_i,       // module clock
    output logic            ovl_sent_o,  // overload frame sent, one-cycle pulse
    output logic      [8:0] tec_o,       // transmit error counter
    output logic      [8:0] rec_o,       // receive error counter
    output logic            rx_done_o,   // error-free reception pulse
    output logic            rx_remote_o, // remote qualifier, valid with the pulse
    output logic      [3:0] rx_mbx_o     // receiving mailbox, valid with the pulse
);
    // quiet engine at time zero; qualifiers start as junk since nothing is received yet
    initial begin
        ovl_sent_o  = 1'b0;
        tec_o       = 9'h000;
        rec_o       = 9'h000;
        rx_done_o   = 1'b0;
        rx_remote_o = 1'b1;
        rx_mbx_o    = 4'hA;
    end

    // counters move as levels at an edge, like the real engine after a bit error
    task automatic counts(input logic [8:0] t, input logic [8:0] r);
        @(posedge clk_i);
        tec_o <= t;
        rec_o <= r;
    endtask

    // one overload frame, one cycle wide
    task automatic overload();
        @(posedge clk_i);
        ovl_sent_o <= 1'b1;
        @(posedge clk_i);
        ovl_sent_o <= 1'b0;
    endtask

    // one reception; afterwards the qualifiers show the inverse so stale values cannot pass
    task automatic receive(input logic [3:0] mbx, input logic remote);
        @(posedge clk_i);
        rx_done_o   <= 1'b1;
        rx_remote_o <= remote;
        rx_mbx_o    <= mbx;
        @(posedge clk_i);
        rx_done_o   <= 1'b0;
        rx_remote_o <= ~remote;
        rx_mbx_o    <= ~mbx;
    endtask
endmodule // can_engine_model
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the upper can flags, their mailbox status and the bus slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; $display("BAD %s expected %h seen %h", nm, ex, got); end end
module testbench;
    logic        clk_i;
    logic        rst_i;
    logic        ce_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq_o;
    logic        ovl;
    logic [8:0]  tec;
    logic [8:0]  rec;
    logic        rx_done;
    logic        rx_remote;
    logic [3:0]  rx_mbx;
    int          errors;
    int          checked;

    can_flag_upper dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o), .ovl_sent_i(ovl), .tec_i(tec), .rec_i(rec), .rx_done_i(rx_done),
        .rx_remote_i(rx_remote), .rx_mbx_i(rx_mbx));
    can_engine_model eng (.clk_i(clk_i), .ovl_sent_o(ovl), .tec_o(tec), .rec_o(rec), .rx_done_o(rx_done),
        .rx_remote_o(rx_remote), .rx_mbx_o(rx_mbx));

    // free-running 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // classic single cycle; the wait is bounded so a dead slave counts as a mismatch
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) errors++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        wb(1'b1, adr, dat, q);
    endtask

    task automatic rd(input string nm, input logic [7:0] adr, input logic [31:0] ex);
        logic [31:0] q;
        wb(1'b0, adr, 32'h0000_0000, q);
        `CHK(nm, ex, q)
    endtask

    // irq is registered behind the status, so let it settle before looking
    task automatic irq_is(input logic ex);
        repeat (3) @(posedge clk_i);
        #1 `CHK("irq", ex, irq_o)
    endtask

    task automatic t_reset();
        rd("mbx_mask", can_flag_pkg::OFS_MBXMASK, 32'h0000_FFFF);
        rd("irq_mask", can_flag_pkg::OFS_IRQMASK, 32'h0000_0000);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_0000);
        wr(8'h18, 32'hFFFF_FFFF);
        rd("unmapped", 8'h18, 32'h0000_0000);
    endtask

    // overload in error active state, interrupt enabled only for it
    task automatic t_overload();
        wr(can_flag_pkg::OFS_IRQMASK, 32'h0000_8000);
        eng.overload();
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_8000);
        irq_is(1'b1);
        wr(can_flag_pkg::OFS_FLAGS, 32'h0000_8000);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_0000);
        rd("irq_stat", can_flag_pkg::OFS_IRQSTAT, 32'h0000_8000);
        irq_is(1'b0);
    endtask

    // counters climb through every threshold; these events stay masked from irq
    task automatic t_errors();
        eng.counts(9'h05F, 9'h05F);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_0000);
        eng.counts(9'h060, 9'h05F);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_0800);
        eng.counts(9'h060, 9'h060);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_1800);
        eng.counts(9'h080, 9'h060);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_3800);
        eng.counts(9'h100, 9'h060);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_7800);
        eng.overload();
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_7800);
        wr(can_flag_pkg::OFS_FLAGS, 32'h0000_0000);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_7800);
        wr(can_flag_pkg::OFS_FLAGS, 32'h0000_7800);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_0000);
        irq_is(1'b0);
        rd("irq_stat", can_flag_pkg::OFS_IRQSTAT, 32'h0000_7800);
        eng.counts(9'h000, 9'h000);
    endtask

    task automatic t_mailbox();
        eng.receive(4'h3, 1'b0);
        rd("rxdone", can_flag_pkg::OFS_RXDONE, 32'h0000_0008);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_0000);
        wr(can_flag_pkg::OFS_MBXMASK, 32'h0000_FFDF);
        eng.receive(4'h5, 1'b1);
        rd("remote", can_flag_pkg::OFS_REMOTE, 32'h0000_0020);
        rd("rxdone", can_flag_pkg::OFS_RXDONE, 32'h0000_0028);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_0600);
        wr(can_flag_pkg::OFS_FLAGS, 32'h0000_0600);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_0600);
        wr(can_flag_pkg::OFS_REMOTE, 32'h0000_0020);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_0200);
        eng.receive(4'h0, 1'b0);
        eng.receive(4'hF, 1'b0);
        rd("rxdone", can_flag_pkg::OFS_RXDONE, 32'h0000_8029);
        wr(can_flag_pkg::OFS_RXDONE, 32'h0000_8008);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_0200);
        wr(can_flag_pkg::OFS_RXDONE, 32'h0000_0021);
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_0000);
        rd("irq_stat", can_flag_pkg::OFS_IRQSTAT, 32'h0000_0600);
    endtask

    // a new reception lands on the very edge of the clearing write
    task automatic t_collide();
        eng.receive(4'h0, 1'b0);
        fork
            wr(can_flag_pkg::OFS_RXDONE, 32'h0000_0001);
            begin
                @(posedge clk_i);
                eng.receive(4'h0, 1'b0);
            end
        join
        rd("rxdone", can_flag_pkg::OFS_RXDONE, 32'h0000_0001);
        wr(can_flag_pkg::OFS_RXDONE, 32'h0000_FFFF);
        rd("rxdone", can_flag_pkg::OFS_RXDONE, 32'h0000_0000);
        // bus-off entry on the very edge of a write of 1 to that flag; the set must win
        fork
            wr(can_flag_pkg::OFS_FLAGS, 32'h0000_4000);
            begin
                @(posedge clk_i);
                eng.counts(9'h100, 9'h000);
            end
        join
        rd("flags", can_flag_pkg::OFS_FLAGS, 32'h0000_6800);
        wr(can_flag_pkg::OFS_FLAGS, 32'h0000_6800);
        eng.counts(9'h000, 9'h000);
        // clock enable low across a reception: nothing may be recorded
        @(posedge clk_i);
        ce_i <= 1'b0;
        eng.receive(4'h1, 1'b0);
        ce_i <= 1'b1;
        rd("frozen", can_flag_pkg::OFS_RXDONE, 32'h0000_0000);
    endtask

    // under two hundred cycles are expected; give over twenty-five times that
    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        report_and_stop();
    end

    initial begin
        errors   = 0;
        checked  = 0;
        rst_i    = 1'b1;
        ce_i     = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i  = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0000_0000;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_overload();
        t_errors();
        t_mailbox();
        t_collide();
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
